// ---- hw/igb_gearbox.sv ----
// Input gearbox: serial link to parallel words for the core
`timescale 1ns/1ps
// Behaviour
// RULE_01 - The gearbox works as a 1:7 deserialiser, one 1:8 gearbox or two 1:4 gearboxes.
// RULE_02 - Seven-bit mode fills word bits 6..0, eight-bit mode fills bits 7..0.
// RULE_03 - In dual four-bit mode lane A drives bits 7..4 and lane C drives bits 3..0.
// RULE_04 - Data passes three register stages: sampling, alignment and core transfer.
// RULE_05 - The first stage samples the serial input on both edges of the fast edge clock.
// RULE_06 - The second stage picks the word boundary under the word alignment request.
// RULE_07 - The third stage presents the aligned word to the core on the slow clock.
// RULE_08 - Core logic drives the word alignment request to move the word boundary.
// RULE_09 - The serial input is taken after a programmable input delay, not from the pad.
// RULE_10 - Reset clears all three stages and returns the boundary selection to its start.
// RULE_11 - Each accepted alignment request moves the boundary by one bit position.
module igb_gearbox (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Serial link pins
	input wire logic i_fast_edge_clock,
	input wire logic i_ser_data_a,
	input wire logic i_ser_data_c,
	// Core-side controls
	input wire igb_pkg::igb_mode_type i_gear_mode,
	input wire logic [igb_pkg::DLY_SEL_W-1:0] i_input_delay,
	input wire logic i_word_align_request,
	// Core-side word and status
	output logic [igb_pkg::WORD_W-1:0] o_data,
	output logic o_word_valid,
	output logic [igb_pkg::CNT_W-1:0] o_align_select
);
	igb_pkg::igb_state_type st_r;
	igb_pkg::igb_state_type st_nxt;
	logic [igb_pkg::SYNC_W-1:0] pins_s;
	logic edge_hit;
	logic [igb_pkg::CNT_W-1:0] last_bit;
	logic [igb_pkg::WORD_W-1:0] sh_a_next;
	logic [igb_pkg::LANE_W-1:0] sh_c_next;
	logic req_take;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation; clock and data share latency so their phase holds

	igb_sync u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_async({i_ser_data_c, i_ser_data_a, i_fast_edge_clock}),
		.o_sync(pins_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode decode

	always_comb begin
		case (i_gear_mode)
			igb_pkg::IGB_VIDEO_SEVEN: last_bit = igb_pkg::LAST_VIDEO; // RULE_01
			igb_pkg::IGB_EIGHT_BIT_GEARING: last_bit = igb_pkg::LAST_EIGHT; // RULE_01
			igb_pkg::IGB_FOUR_BIT_GEARING: last_bit = igb_pkg::LAST_FOUR; // RULE_01
			default: last_bit = igb_pkg::LAST_EIGHT;
		endcase
	end

	assign edge_hit = pins_s[igb_pkg::SY_CLK] != st_r.edge_clk_prev;
	assign req_take = i_word_align_request && !st_r.slip_pend;
	assign sh_a_next = {st_r.s1_a, st_r.sh_a[igb_pkg::WORD_W-1:1]};
	assign sh_c_next = {st_r.s1_c, st_r.sh_c[igb_pkg::LANE_W-1:1]};

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt = st_r;
		st_nxt.edge_clk_prev = pins_s[igb_pkg::SY_CLK];
		// Delay line in front of the sampler
		st_nxt.dly_a = {st_r.dly_a[igb_pkg::DLY_TAPS-2:0], pins_s[igb_pkg::SY_DA]}; // RULE_09
		st_nxt.dly_c = {st_r.dly_c[igb_pkg::DLY_TAPS-2:0], pins_s[igb_pkg::SY_DC]}; // RULE_09
		// Stage one: one bit per rising and per falling edge
		st_nxt.s1_vld = edge_hit; // RULE_05
		if (edge_hit) begin
			st_nxt.s1_a = st_r.dly_a[i_input_delay]; // RULE_09
			st_nxt.s1_c = st_r.dly_c[i_input_delay]; // RULE_09
		end
		// Request is held until the next bit arrives, then slips one bit
		if (req_take) begin
			st_nxt.slip_pend = 1'b1; // RULE_08
		end
		// Stage two: word assembly at the selected boundary
		st_nxt.s2.valid = 1'b0;
		if (st_r.s1_vld) begin
			if (st_r.slip_pend) begin
				st_nxt.slip_pend = 1'b0; // RULE_11
				if (st_r.align_sel == last_bit) begin
					st_nxt.align_sel = igb_pkg::CNT_RST; // RULE_06
				end else begin
					st_nxt.align_sel = st_r.align_sel + igb_pkg::CNT_ONE; // RULE_06
				end
			end else begin
				st_nxt.sh_a = sh_a_next;
				st_nxt.sh_c = sh_c_next;
				if (st_r.cnt >= last_bit) begin
					st_nxt.cnt = igb_pkg::CNT_RST;
					st_nxt.s2.valid = 1'b1; // RULE_04
					case (i_gear_mode)
						igb_pkg::IGB_VIDEO_SEVEN: begin
							st_nxt.s2.data = {1'b0, sh_a_next[igb_pkg::WORD_W-1:1]}; // RULE_02
						end
						igb_pkg::IGB_FOUR_BIT_GEARING: begin
							st_nxt.s2.data = {sh_a_next[igb_pkg::WORD_W-1:igb_pkg::LANE_W],
								sh_c_next}; // RULE_03
						end
						default: begin
							st_nxt.s2.data = sh_a_next; // RULE_02
						end
					endcase
				end else begin
					st_nxt.cnt = st_r.cnt + igb_pkg::CNT_ONE;
				end
			end
		end
		// Stage three: hand-over to the core
		st_nxt.s3.valid = st_r.s2.valid; // RULE_07
		if (st_r.s2.valid) begin
			st_nxt.s3.data = st_r.s2.data; // RULE_07
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r.edge_clk_prev <= 1'b0;
			st_r.dly_a <= igb_pkg::DLY_RST;
			st_r.dly_c <= igb_pkg::DLY_RST;
			st_r.s1_a <= 1'b0; // RULE_10
			st_r.s1_c <= 1'b0; // RULE_10
			st_r.s1_vld <= 1'b0; // RULE_10
			st_r.sh_a <= igb_pkg::WORD_RST;
			st_r.sh_c <= igb_pkg::WORD_RST[igb_pkg::LANE_W-1:0];
			st_r.cnt <= igb_pkg::CNT_RST;
			st_r.slip_pend <= 1'b0;
			st_r.align_sel <= igb_pkg::CNT_RST; // RULE_10
			st_r.s2.data <= igb_pkg::WORD_RST; // RULE_10
			st_r.s2.valid <= 1'b0;
			st_r.s3.data <= igb_pkg::WORD_RST; // RULE_10
			st_r.s3.valid <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_data = st_r.s3.data;
	assign o_word_valid = st_r.s3.valid;
	assign o_align_select = st_r.align_sel;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	AST_EDGE_SAMPLE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_05
		edge_hit |=> st_r.s1_vld && st_r.s1_a == $past(st_r.dly_a[i_input_delay]))
		else $error("edge did not sample the delayed bit");

	AST_NO_EDGE_NO_SAMPLE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_05
		!edge_hit |=> !st_r.s1_vld)
		else $error("sample taken without a link clock edge");

	AST_PIPE_DEPTH: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_04
		st_r.s2.valid |=> o_word_valid && o_data == $past(st_r.s2.data))
		else $error("aligned word not handed on next cycle");

	AST_VIDEO_TOP_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_02
		(st_r.s1_vld && !st_r.slip_pend && st_r.cnt == igb_pkg::LAST_VIDEO
		&& i_gear_mode == igb_pkg::IGB_VIDEO_SEVEN) |=> ##1 o_word_valid && !o_data[7])
		else $error("seven-bit word has bit 7 set or was late");

	AST_DUAL_LANE_C: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_03
		(st_r.s1_vld && !st_r.slip_pend && st_r.cnt == igb_pkg::LAST_FOUR
		&& i_gear_mode == igb_pkg::IGB_FOUR_BIT_GEARING)
		|=> ##1 o_data[3:0] == $past(sh_c_next, 2))
		else $error("lane C word not on low nibble");

	AST_SLIP_STEP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_11
		(st_r.s1_vld && st_r.slip_pend && st_r.align_sel != last_bit)
		|=> o_align_select == $past(st_r.align_sel) + igb_pkg::CNT_ONE
		&& $stable(st_r.cnt))
		else $error("accepted request did not slip one bit");

	AST_REQ_ACCEPT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_06
		req_take |=> st_r.slip_pend)
		else $error("alignment request not taken");

	AST_OUT_PULSE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_07
		o_word_valid |=> !o_word_valid)
		else $error("word valid held longer than one cycle");

	AST_RESET_CLEAR: assert property (@(posedge i_sys_clk) // RULE_10
		!i_rst_b |-> o_align_select == igb_pkg::CNT_RST && !o_word_valid
		&& !st_r.s2.valid && !st_r.s1_vld)
		else $error("reset left pipeline or boundary set");

	AST_WORD_COUNT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_01
		st_r.s2.valid |-> st_r.cnt == igb_pkg::CNT_RST)
		else $error("word emitted with bit counter not at zero");

	AST_LANE_A_TOP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_03
		(st_r.s1_vld && !st_r.slip_pend && st_r.cnt == igb_pkg::LAST_FOUR
		&& i_gear_mode == igb_pkg::IGB_FOUR_BIT_GEARING) |=> ##1
		o_data[igb_pkg::WORD_W-1:igb_pkg::LANE_W] == $past(sh_a_next[igb_pkg::WORD_W-1:igb_pkg::LANE_W], 2))
		else $error("lane A word not on high nibble");

	AST_SLIP_DROPS_BIT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_11
		(st_r.s1_vld && st_r.slip_pend)
		|=> $stable(st_r.sh_a) && $stable(st_r.cnt) && !st_r.s2.valid)
		else $error("slipped bit entered the word");

	AST_SLIP_WRAP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_06
		(st_r.s1_vld && st_r.slip_pend && st_r.align_sel == last_bit)
		|=> o_align_select == igb_pkg::CNT_RST)
		else $error("boundary selection did not wrap");

	AST_WORD_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE_07
		!st_r.s2.valid |=> $stable(o_data))
		else $error("core word changed without a new word");
endmodule

// ---- hw/igb_pkg.sv ----
// Shared constants and types for the input gearbox deserialiser
package igb_pkg;
	localparam int unsigned WORD_W = 8;
	localparam int unsigned LANE_W = 4;
	localparam int unsigned DLY_TAPS = 8;
	localparam int unsigned DLY_SEL_W = 3;
	localparam int unsigned CNT_W = 3;
	localparam int unsigned SYNC_W = 3;
	localparam logic [CNT_W-1:0] LAST_VIDEO = 3'h6;
	localparam logic [CNT_W-1:0] LAST_EIGHT = 3'h7;
	localparam logic [CNT_W-1:0] LAST_FOUR = 3'h3;
	localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
	localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
	localparam logic [DLY_TAPS-1:0] DLY_RST = 8'h00;
	localparam logic [SYNC_W-1:0] SYNC_RST = 3'h0;
	// Index of each pin in the synchroniser bus
	localparam int unsigned SY_CLK = 0;
	localparam int unsigned SY_DA = 1;
	localparam int unsigned SY_DC = 2;

	typedef enum logic [1:0] {
		IGB_VIDEO_SEVEN = 2'b00,
		IGB_EIGHT_BIT_GEARING = 2'b01,
		IGB_FOUR_BIT_GEARING = 2'b10
	} igb_mode_type;

	typedef struct packed {
		logic [WORD_W-1:0] data;
		logic valid;
	} igb_word_type;

	typedef struct packed {
		logic edge_clk_prev;
		logic [DLY_TAPS-1:0] dly_a;
		logic [DLY_TAPS-1:0] dly_c;
		logic s1_a;
		logic s1_c;
		logic s1_vld;
		logic [WORD_W-1:0] sh_a;
		logic [LANE_W-1:0] sh_c;
		logic [CNT_W-1:0] cnt;
		logic slip_pend;
		logic [CNT_W-1:0] align_sel;
		igb_word_type s2;
		igb_word_type s3;
	} igb_state_type;
endpackage

// ---- hw/igb_sync.sv ----
// Two-flop synchroniser for pins arriving from outside the system clock
`timescale 1ns/1ps
module igb_sync (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Asynchronous pins and their synchronised copies
	input wire logic [igb_pkg::SYNC_W-1:0] i_async,
	output logic [igb_pkg::SYNC_W-1:0] o_sync
);
	logic [igb_pkg::SYNC_W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_r <= igb_pkg::SYNC_RST;
			o_sync <= igb_pkg::SYNC_RST;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule

// ---- testbench/igb_tx_model.sv ----
// Serial transmitter model driving the gearbox link pins
`timescale 1ns/1ps
module igb_tx_model (
	// Link pins
	output logic o_edge_clk,
	output logic o_data_a,
	output logic o_data_c
);
	initial begin
		o_edge_clk = 1'b0;
		o_data_a = 1'b0;
		o_data_c = 1'b0;
	end
	// Data settles a quarter period either side of each edge
	task automatic send(input logic [15:0] a, input logic [15:0] c, input int n, input realtime h);
		// Start off the bench clock grid so no pin change meets a sampling edge
		#(h / 4);
		for (int i = 0; i < n; i++) begin
			o_data_a = a[i];
			o_data_c = c[i];
			#(h / 2);
			o_edge_clk = ~o_edge_clk;
			#(h / 2);
		end
		// Released lines show the inverse, never a stale bit
		o_data_a = ~o_data_a;
		o_data_c = ~o_data_c;
	endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the input gearbox
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		igb_pkg::igb_mode_type mode;
		logic [2:0] dly;
		logic [15:0] a;
		logic [15:0] c;
		int n;
		logic [7:0] e0;
		logic [7:0] e1;
	} igb_row_type;
	localparam igb_pkg::igb_mode_type EB = igb_pkg::IGB_EIGHT_BIT_GEARING;
	localparam igb_pkg::igb_mode_type VS = igb_pkg::IGB_VIDEO_SEVEN;
	localparam igb_pkg::igb_mode_type FB = igb_pkg::IGB_FOUR_BIT_GEARING;
	// Every row sends two back-to-back words and ends with the link clock low
	igb_row_type rows [6] = '{
		'{EB, 3'h0, 16'h3CA5, 16'h0000, 16, 8'hA5, 8'h3C},
		'{VS, 3'h0, 16'h1B49, 16'h0000, 14, 8'h49, 8'h36},
		'{FB, 3'h0, 16'h0096, 16'h0069, 8, 8'h69, 8'h96},
		'{EB, 3'h2, 16'h7E81, 16'h0000, 16, 8'h81, 8'h7E},
		'{FB, 3'h2, 16'h00C5, 16'h003A, 8, 8'h5A, 8'hC3},
		'{VS, 3'h1, 16'h007F, 16'h0000, 14, 8'h7F, 8'h00}};
	logic sys_clk = 1'b0;
	// Starts high so the first reset is a real falling edge
	logic rst_b = 1'b1;
	logic edge_clk;
	logic ser_a;
	logic ser_c;
	igb_pkg::igb_mode_type gear_mode = EB;
	logic [2:0] input_delay = 3'h0;
	logic align_req = 1'b0;
	logic [7:0] data;
	logic word_valid;
	logic [2:0] align_sel;
	logic [7:0] seen_q [$];
	int error_cnt = 0;
	int total_checks = 0;

	always #4 sys_clk = ~sys_clk;

	igb_tx_model tx_u (.o_edge_clk(edge_clk), .o_data_a(ser_a), .o_data_c(ser_c));
	igb_gearbox dut_u (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_fast_edge_clock(edge_clk),
		.i_ser_data_a(ser_a), .i_ser_data_c(ser_c), .i_gear_mode(gear_mode),
		.i_input_delay(input_delay), .i_word_align_request(align_req), .o_data(data),
		.o_word_valid(word_valid), .o_align_select(align_sel));

	always @(posedge sys_clk) begin
		if (word_valid === 1'b1) begin
			seen_q.push_back(data);
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("Checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		seen_q.delete();
		check("reset data", data, 8'h00);
		check("reset select", {5'h00, align_sel}, 8'h00);
	endtask

	// Words must land within a short bound after the last link edge
	task automatic take(input string what, input logic [7:0] e0, input logic [7:0] e1, input int k);
		int t;
		for (t = 0; t < 20 && seen_q.size() < k; t++) begin
			@(posedge sys_clk);
		end
		if (seen_q.size() < k) begin
			error_cnt++;
			$display("Error %s expected words seen none", what);
			conclude();
		end else begin
			check(what, seen_q.pop_front(), e0);
			if (k > 1) begin
				check(what, seen_q.pop_front(), e1);
			end
			check("word count", 8'(seen_q.size()), 8'h00);
			$display("Test %s done", what);
		end
	endtask

	task automatic slip(input int hold);
		@(posedge sys_clk);
		align_req <= 1'b1;
		repeat (hold) @(posedge sys_clk);
		align_req <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		foreach (rows[i]) begin
			gear_mode <= rows[i].mode;
			input_delay <= rows[i].dly;
			do_reset();
			tx_u.send(rows[i].a, rows[i].c, rows[i].n, 62.5);
			take("row word", rows[i].e0, rows[i].e1, 2);
		end
		gear_mode <= EB;
		input_delay <= 3'h0;
		do_reset();
		slip(1);
		tx_u.send(16'h01A5, 16'h0000, 9, 62.5);
		take("one slip", 8'hD2, 8'h00, 1);
		check("select one", {5'h00, align_sel}, 8'h01);
		// Request held while pending yields a single slip, slow link
		slip(3);
		tx_u.send(16'h0097, 16'h0000, 9, 100.0);
		take("held slip", 8'h4B, 8'h00, 1);
		check("select two", {5'h00, align_sel}, 8'h02);
		// Four slips in dual four-bit mode bring the boundary back to start
		gear_mode <= FB;
		do_reset();
		for (int s = 1; s <= 4; s++) begin
			slip(1);
			tx_u.send(16'hFFFF, 16'hFFFF, 1, 62.5);
			repeat (2) @(posedge sys_clk);
			check("wrap select", {5'h00, align_sel}, 8'(s % 4));
		end
		tx_u.send(16'h0009, 16'h0006, 4, 62.5);
		take("wrap word", 8'h96, 8'h00, 1);
		do_reset();
		conclude();
	end
endmodule
